// ---- design/lsw_pkg.sv ----
// Package for the loop status word logic
package lsw_pkg;

    // Word offsets in the host input area
    localparam logic [7:0] LSW_THIRD_OFFSET  = 8'h12;
    localparam logic [7:0] LSW_FOURTH_OFFSET = 8'h13;

    // Bit positions of the status word
    localparam int LSW_SAVE_DONE_BIT   = 15;
    localparam int LSW_SENSOR_BIT      = 14;
    localparam int LSW_RSVD13_BIT      = 13;
    localparam int LSW_FATAL_BIT       = 12;
    localparam int LSW_STANDBY_BIT     = 11;
    localparam int LSW_TUNE_PEND_BIT   = 10;
    localparam int LSW_SET_ERR_BIT     = 9;
    localparam int LSW_STOP_BIT        = 8;
    localparam int LSW_CTRL_OUT_BIT    = 4;
    localparam int LSW_AT_BIT          = 3;
    localparam int LSW_ALARM1_BIT      = 1;
    localparam int LSW_ALARM2_BIT      = 0;

    // Save request bit of the host save word for the fourth loop
    localparam int LSW_SAVE_REQ_BIT    = 14;

    localparam logic [15:0] LSW_WORD_RESET = 16'h0000;

    // Temperature range limits, tenths of a degree
    localparam logic signed [15:0] LSW_TEMP_MIN = 16'shfe0c;
    localparam logic signed [15:0] LSW_TEMP_MAX = 16'sh0514;

    // Per-loop condition inputs from the control core
    typedef struct packed {
        logic               regulating;
        logic               ctrl_out_on;
        logic               tune_running;
        logic               tune_result;
        logic               setting_invalid;
        logic               sensor_absent;
        logic               sensor_broken;
        logic signed [15:0] temp;
        logic signed [15:0] al1_lo;
        logic signed [15:0] al1_hi;
        logic signed [15:0] al2_lo;
        logic signed [15:0] al2_hi;
    } lsw_loop_in_t;

    // Save engine handshake
    typedef struct packed {
        logic busy;
        logic done;
    } lsw_save_stat_t;

    typedef enum logic [1:0] {LSW_SAVE_IDLE, LSW_SAVE_RUN, LSW_SAVE_FIN} lsw_save_state_t;

    function automatic logic lsw_in_range(input logic signed [15:0] v,
                                          input logic signed [15:0] lo,
                                          input logic signed [15:0] hi);
        lsw_in_range = (v >= lo) && (v <= hi);
    endfunction

endpackage

// ---- design/lsw_save_ctl.sv ----
// Save request tracking and save-completed flag for one loop
module lsw_save_ctl
    import lsw_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           save_req,
    input  lsw_pkg::lsw_save_stat_t eng,
    output logic                save_start,
    output logic                save_done_flag
);
    import lsw_pkg::*;

    logic            req_q;
    logic            next_req_q;
    logic            next_flag;
    lsw_save_state_t state;
    lsw_save_state_t next_state;

    always_comb
    begin
        next_req_q = save_req;
        next_flag  = save_done_flag;
        next_state = state;
        save_start = 1'b0;
        case (state)
            LSW_SAVE_IDLE:
            begin
                if (save_req && !req_q)
                begin
                    save_start = 1'b1;
                    next_state = LSW_SAVE_RUN;
                end
            end
            LSW_SAVE_RUN:
            begin
                if (eng.done)
                    next_state = LSW_SAVE_FIN;
            end
            LSW_SAVE_FIN:
            begin
                next_state = LSW_SAVE_IDLE;
            end
            default:
            begin
                next_state = LSW_SAVE_IDLE;
            end
        endcase
        if (save_req && !req_q)
            next_flag = 1'b0;
        // Set on save end; set wins over a same-cycle request
        if (state == LSW_SAVE_FIN)
            next_flag = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_q          <= 1'b0;
            save_done_flag <= 1'b0;
            state          <= LSW_SAVE_IDLE;
        end
        else
        begin
            req_q          <= next_req_q;
            save_done_flag <= next_flag;
            state          <= next_state;
        end
    end

    a_save_clear: assert property (@(posedge clk) disable iff (rst)
        (save_req && !req_q && state != LSW_SAVE_FIN) |=> !save_done_flag) else $error("save flag not cleared");

    a_save_set: assert property (@(posedge clk) disable iff (rst)
        (state == LSW_SAVE_RUN && eng.done) |=> ##1 save_done_flag) else $error("save flag not set");

endmodule // lsw_save_ctl

// ---- design/lsw_status_word.sv ----
// Loop status word logic: builds the third and fourth loop status words
module lsw_status_word
    import lsw_pkg::*;
#(
    parameter int LOOPS = 2
)
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  lsw_pkg::lsw_loop_in_t    loop_in    [LOOPS],
    input  wire logic [LOOPS-1:0]    host_const_written,
    input  wire logic [LOOPS-1:0]    save_req,
    input  lsw_pkg::lsw_save_stat_t  save_eng   [LOOPS],
    input  wire logic [LOOPS-1:0]    fatal_err,
    input  wire logic                standby,
    input  wire logic                refresh,
    input  wire logic [7:0]          rd_offset,
    output logic [LOOPS-1:0]         save_start,
    output logic [15:0]              rd_data,
    output logic [15:0]              status_word [LOOPS]
);
    import lsw_pkg::*;

    logic [LOOPS-1:0] pending;
    logic [LOOPS-1:0] save_done;
    logic [15:0]      live_word  [LOOPS];
    logic [15:0]      next_word  [LOOPS];
    logic [15:0]      next_rd;

    // Word assembly from raw conditions
    function automatic logic [15:0] lsw_build(input lsw_loop_in_t li,
                                              input logic pend,
                                              input logic sdone,
                                              input logic fatal,
                                              input logic stby);
        logic [15:0] w;
        w = LSW_WORD_RESET;
        w[LSW_SAVE_DONE_BIT] = sdone;
        w[LSW_SENSOR_BIT]    = li.sensor_absent || li.sensor_broken ||
                               (li.temp < LSW_TEMP_MIN) || (li.temp > LSW_TEMP_MAX);
        w[LSW_FATAL_BIT]     = fatal;
        w[LSW_STANDBY_BIT]   = stby;
        w[LSW_TUNE_PEND_BIT] = pend;
        w[LSW_SET_ERR_BIT]   = li.setting_invalid;
        w[LSW_STOP_BIT]      = !li.regulating;
        w[LSW_CTRL_OUT_BIT]  = li.ctrl_out_on;
        w[LSW_AT_BIT]        = li.tune_running;
        w[LSW_ALARM1_BIT]    = lsw_in_range(li.temp, li.al1_lo, li.al1_hi);
        w[LSW_ALARM2_BIT]    = lsw_in_range(li.temp, li.al2_lo, li.al2_hi);
        // Reserved bits stay zero from reset value
        lsw_build = w;
    endfunction

    genvar g;
    generate
        for (g = 0; g < LOOPS; g++)
        begin : g_loop
            lsw_tune_track u_tune (
                .clk               (clk),
                .rst               (rst),
                .tune_result       (loop_in[g].tune_result),
                .host_area_written (host_const_written[g]),
                .pending           (pending[g])
            );

            // Host save request starts the save engine
            lsw_save_ctl u_save (
                .clk            (clk),
                .rst            (rst),
                .save_req       (save_req[g]),
                .eng            (save_eng[g]),
                .save_start     (save_start[g]),
                .save_done_flag (save_done[g])
            );

            assign live_word[g] = lsw_build(loop_in[g], pending[g], save_done[g], fatal_err[g], standby);
        end
    endgenerate

    always_comb
    begin
        for (int i = 0; i < LOOPS; i++)
        begin
            next_word[i] = refresh ? live_word[i] : status_word[i];
        end
        case (rd_offset)
            LSW_THIRD_OFFSET:  next_rd = status_word[0];
            LSW_FOURTH_OFFSET: next_rd = status_word[LOOPS-1];
            default:           next_rd = LSW_WORD_RESET;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < LOOPS; i++)
            begin
                status_word[i] <= LSW_WORD_RESET;
            end
            rd_data <= LSW_WORD_RESET;
        end
        else
        begin
            status_word <= next_word;
            rd_data     <= next_rd;
        end
    end

    // Checks on the published word of the first loop
    sequence s_refresh;
        refresh;
    endsequence

    a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        (status_word[0][7:5] == 3'h0) && !status_word[0][2] && !status_word[0][LSW_RSVD13_BIT])
        else $error("reserved bit set");

    a_stop_flag: assert property (@(posedge clk) disable iff (rst)
        s_refresh |=> status_word[0][LSW_STOP_BIT] == !$past(loop_in[0].regulating))
        else $error("stop flag wrong");

    a_ctrl_out: assert property (@(posedge clk) disable iff (rst)
        s_refresh |=> status_word[0][LSW_CTRL_OUT_BIT] == $past(loop_in[0].ctrl_out_on))
        else $error("control output flag wrong");

    a_autotune_active_flag: assert property (@(posedge clk) disable iff (rst)
        s_refresh |=> status_word[0][LSW_AT_BIT] == $past(loop_in[0].tune_running))
        else $error("autotune flag wrong");

    a_set_err: assert property (@(posedge clk) disable iff (rst)
        s_refresh |=> status_word[0][LSW_SET_ERR_BIT] == $past(loop_in[0].setting_invalid))
        else $error("setting error flag wrong");

    a_sensor_flt: assert property (@(posedge clk) disable iff (rst)
        (refresh && (loop_in[0].sensor_absent || loop_in[0].sensor_broken)) |=> status_word[0][LSW_SENSOR_BIT])
        else $error("sensor fault missing");

    a_word_hold: assert property (@(posedge clk) disable iff (rst)
        !refresh |=> $stable(status_word[0])) else $error("word changed between refreshes");

    // Offset decode, one cycle behind the request
    sequence s_rd_third;
        rd_offset == LSW_THIRD_OFFSET;
    endsequence

    sequence s_rd_fourth;
        rd_offset == LSW_FOURTH_OFFSET;
    endsequence

    sequence s_rd_other;
        (rd_offset != LSW_THIRD_OFFSET) && (rd_offset != LSW_FOURTH_OFFSET);
    endsequence

    a_rd_third: assert property (@(posedge clk) disable iff (rst)
        s_rd_third |=> rd_data == $past(status_word[0]))
        else $error("third word read wrong");

    a_rd_fourth: assert property (@(posedge clk) disable iff (rst)
        s_rd_fourth |=> rd_data == $past(status_word[LOOPS-1]))
        else $error("fourth word read wrong");

    // Unused offsets read zero
    a_rd_other: assert property (@(posedge clk) disable iff (rst)
        s_rd_other |=> rd_data == LSW_WORD_RESET)
        else $error("unused offset not zero");

    // Same flag checks on every loop, fourth loop included
    for (genvar k = 0; k < LOOPS; k++)
    begin : g_chk
        a_stop_run: assert property (@(posedge clk) disable iff (rst)
            (refresh && loop_in[k].regulating) |=> !status_word[k][LSW_STOP_BIT])
            else $error("stop flag set while regulating");

        a_stop_idle: assert property (@(posedge clk) disable iff (rst)
            (refresh && !loop_in[k].regulating) |=> status_word[k][LSW_STOP_BIT])
            else $error("stop flag clear while idle");

        a_ctrl_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_CTRL_OUT_BIT] == $past(loop_in[k].ctrl_out_on))
            else $error("control output flag wrong");

        a_at_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_AT_BIT] == $past(loop_in[k].tune_running))
            else $error("autotune flag wrong");

        a_err_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_SET_ERR_BIT] == $past(loop_in[k].setting_invalid))
            else $error("setting error flag wrong");

        a_alarm_first: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_ALARM1_BIT] ==
            $past((loop_in[k].temp >= loop_in[k].al1_lo) && (loop_in[k].temp <= loop_in[k].al1_hi)))
            else $error("first alarm flag wrong");

        a_alarm_second: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_ALARM2_BIT] ==
            $past((loop_in[k].temp >= loop_in[k].al2_lo) && (loop_in[k].temp <= loop_in[k].al2_hi)))
            else $error("second alarm flag wrong");

        a_sensor_wire: assert property (@(posedge clk) disable iff (rst)
            (refresh && (loop_in[k].sensor_absent || loop_in[k].sensor_broken)) |=> status_word[k][LSW_SENSOR_BIT])
            else $error("sensor wiring fault missing");

        a_sensor_range: assert property (@(posedge clk) disable iff (rst)
            (refresh && ((loop_in[k].temp < LSW_TEMP_MIN) || (loop_in[k].temp > LSW_TEMP_MAX))) |=>
            status_word[k][LSW_SENSOR_BIT])
            else $error("sensor range fault missing");

        a_sensor_ok: assert property (@(posedge clk) disable iff (rst)
            (refresh && !loop_in[k].sensor_absent && !loop_in[k].sensor_broken &&
             (loop_in[k].temp >= LSW_TEMP_MIN) && (loop_in[k].temp <= LSW_TEMP_MAX)) |=>
            !status_word[k][LSW_SENSOR_BIT])
            else $error("sensor flag without fault");

        a_pend_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_TUNE_PEND_BIT] == $past(pending[k]))
            else $error("pending flag not published");

        a_save_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_SAVE_DONE_BIT] == $past(save_done[k]))
            else $error("save flag not published");

        // Fatal bit copied
        a_fatal_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_FATAL_BIT] == $past(fatal_err[k]))
            else $error("fatal flag wrong");

        // Standby bit copied
        a_standby_copy: assert property (@(posedge clk) disable iff (rst)
            s_refresh |=> status_word[k][LSW_STANDBY_BIT] == $past(standby))
            else $error("standby flag wrong");

        a_rsvd_each: assert property (@(posedge clk) disable iff (rst)
            (status_word[k][7:5] == 3'h0) && !status_word[k][2] && !status_word[k][LSW_RSVD13_BIT])
            else $error("reserved bit set");

        a_hold_each: assert property (@(posedge clk) disable iff (rst)
            !refresh |=> $stable(status_word[k]))
            else $error("word changed between refreshes");

        a_start_req: assert property (@(posedge clk) disable iff (rst)
            save_start[k] |-> save_req[k])
            else $error("save start without request");

        a_start_once: assert property (@(posedge clk) disable iff (rst)
            save_start[k] |=> !save_start[k])
            else $error("save start longer than one cycle");
    end

endmodule // lsw_status_word

// ---- design/lsw_tune_track.sv ----
// Tuning-constants-pending tracker for one loop
module lsw_tune_track
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tune_result,
    input  wire logic host_area_written,
    output logic      pending
);
    logic next_pending;

    always_comb
    begin
        next_pending = pending;
        if (host_area_written)
            next_pending = 1'b0;
        // New constants; set wins over clear
        if (tune_result)
            next_pending = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            pending <= 1'b0;
        else
            pending <= next_pending;
    end

    a_tune_set: assert property (@(posedge clk) disable iff (rst)
        tune_result |=> pending) else $error("pending not set");

    a_tune_clear: assert property (@(posedge clk) disable iff (rst)
        (host_area_written && !tune_result) |=> !pending) else $error("pending not cleared");

endmodule // lsw_tune_track

// ---- sim/lsw_nv_model.sv ----
// Nonvolatile save engine stand-in answering save starts
module lsw_nv_model
    import lsw_pkg::*;
#(
    parameter int LAT = 3
)
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               save_start,
    output lsw_pkg::lsw_save_stat_t eng
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;

    always_comb
    begin
        next_cnt = cnt;
        if (save_start)
            next_cnt = 8'(LAT);
        else if (cnt != 8'h00)
            next_cnt = cnt - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt <= 8'h00;
        else
            cnt <= next_cnt;
    end

    // Done pulses once, as the copy ends
    assign eng.busy = (cnt != 8'h00);
    assign eng.done = (cnt == 8'h01);
endmodule // lsw_nv_model

// ---- sim/lsw_status_word_tb_top.sv ----
// Self-checking bench for the loop status word logic
module lsw_status_word_tb_top
    import lsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk;
    logic           rst;
    lsw_loop_in_t   loop_in [2];
    logic [1:0]     host_const_written;
    logic [1:0]     save_req;
    lsw_save_stat_t save_eng [2];
    logic [1:0]     fatal_err;
    logic           standby;
    logic           refresh;
    logic [7:0]     rd_offset;
    logic [1:0]     save_start;
    logic [15:0]    rd_data;
    logic [15:0]    status_word [2];
    logic [1:0]     pend_e;
    logic [1:0]     sdone_e;
    int             mismatches;
    int             compares;

    lsw_status_word #(.LOOPS(2)) lsw_status_word_i (.clk(clk), .rst(rst), .loop_in(loop_in),
        .host_const_written(host_const_written), .save_req(save_req), .save_eng(save_eng),
        .fatal_err(fatal_err), .standby(standby), .refresh(refresh), .rd_offset(rd_offset),
        .save_start(save_start), .rd_data(rd_data), .status_word(status_word));

    // Prompt engine on loop 0, slow one on loop 1
    for (genvar g = 0; g < 2; g++)
    begin : g_nv
        lsw_nv_model #(.LAT(2 + 7 * g)) lsw_nv_model_i (.clk(clk), .rst(rst),
            .save_start(save_start[g]), .eng(save_eng[g]));
    end

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic lsw_loop_in_t mk(logic rg, logic co, logic tr, logic inv, logic ab, logic br,
                                        logic signed [15:0] t);
        return '{rg, co, tr, 1'b0, inv, ab, br, t, 16'sh0064, 16'sh012c, 16'sh0190, 16'sh01f4};
    endfunction

    function automatic logic [15:0] exp_word(int l);
        lsw_loop_in_t c;
        logic [15:0]  w;
        c = loop_in[l];
        w = 16'h0000;
        w[15] = sdone_e[l];
        w[14] = c.sensor_absent | c.sensor_broken | (c.temp < LSW_TEMP_MIN) | (c.temp > LSW_TEMP_MAX);
        w[12] = fatal_err[l];
        w[11] = standby;
        w[10] = pend_e[l];
        w[9] = c.setting_invalid;
        w[8] = ~c.regulating;
        w[4] = c.ctrl_out_on;
        w[3] = c.tune_running;
        w[1] = (c.temp >= c.al1_lo) && (c.temp <= c.al1_hi);
        w[0] = (c.temp >= c.al2_lo) && (c.temp <= c.al2_hi);
        return w;
    endfunction

    task automatic summarize();
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk16(logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Words only change at a refresh edge
    task automatic snap();
        @(posedge clk);
        refresh <= 1'b1;
        @(posedge clk);
        refresh <= 1'b0;
        #1;
    endtask

    task automatic t_case(int l, lsw_loop_in_t c);
        @(posedge clk);
        loop_in[l] <= c;
        snap();
        chk16(status_word[l], exp_word(l));
        chk16(status_word[l] & 16'h20e4, 16'h0000);
    endtask

    task automatic t_flags();
        t_case(1, mk(1, 1, 0, 0, 0, 0, 16'sh00c8));
        t_case(1, mk(0, 0, 1, 0, 0, 0, 16'sh012c));
        t_case(0, mk(1, 0, 0, 1, 0, 0, 16'sh0190));
        t_case(0, mk(1, 0, 0, 0, 1, 0, 16'sh0063));
        t_case(1, mk(1, 0, 0, 0, 0, 1, 16'sh01f4));
        t_case(1, mk(1, 1, 1, 0, 0, 0, 16'sh0515));
        t_case(0, mk(0, 1, 0, 0, 0, 0, 16'shfe0b));
        t_case(0, mk(1, 0, 0, 0, 0, 0, 16'sh0514));
    endtask

    task automatic t_tune();
        @(posedge clk);
        loop_in[1].tune_result <= 1'b1;
        @(posedge clk);
        loop_in[1].tune_result <= 1'b0;
        snap();
        pend_e[1] = 1'b1;
        chk16(status_word[1], exp_word(1));
        @(posedge clk);
        host_const_written[1] <= 1'b1;
        @(posedge clk);
        host_const_written[1] <= 1'b0;
        snap();
        pend_e[1] = 1'b0;
        chk16(status_word[1], exp_word(1));
    endtask

    task automatic t_rd();
        logic [15:0] w1;
        @(posedge clk);
        fatal_err <= 2'b10;
        standby <= 1'b1;
        snap();
        w1 = exp_word(1);
        @(posedge clk);
        loop_in[1].regulating <= ~loop_in[1].regulating;
        rd_offset <= LSW_THIRD_OFFSET;
        @(posedge clk);
        rd_offset <= LSW_FOURTH_OFFSET;
        #1;
        chk16(rd_data, exp_word(0));
        @(posedge clk);
        rd_offset <= 8'h14;
        #1;
        chk16(rd_data, w1);
        chk16(status_word[1], w1);
        @(posedge clk);
        #1;
        chk16(rd_data, 16'h0000);
    endtask

    task automatic wait_done(int l);
        int n;
        n = 0;
        while (save_eng[l].done !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk16({15'h0000, save_eng[l].done}, 16'h0001);
    endtask

    task automatic t_save(int l);
        @(posedge clk);
        save_req[l] <= 1'b1;
        #1;
        chk16({15'h0000, save_start[l]}, 16'h0001);
        wait_done(l);
        repeat (2) @(posedge clk);
        snap();
        sdone_e[l] = 1'b1;
        chk16(status_word[l], exp_word(l));
        @(posedge clk);
        save_req[l] <= 1'b0;
        @(posedge clk);
        save_req[l] <= 1'b1;
        snap();
        sdone_e[l] = 1'b0;
        chk16(status_word[l], exp_word(l));
    endtask

    initial
    begin
        rst = 1'b1;
        loop_in[0] = mk(1, 0, 0, 0, 0, 0, 16'sh00c8);
        loop_in[1] = mk(1, 0, 0, 0, 0, 0, 16'sh00c8);
        host_const_written = 2'b00;
        save_req = 2'b00;
        fatal_err = 2'b00;
        standby = 1'b0;
        refresh = 1'b0;
        rd_offset = 8'h00;
        pend_e = 2'b00;
        sdone_e = 2'b00;
        mismatches = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk16(status_word[0], 16'h0000);
        chk16(status_word[1], 16'h0000);
        chk16(rd_data, 16'h0000);
        t_flags();
        t_tune();
        t_rd();
        t_save(0);
        t_save(1);
        summarize();
    end

    // Whole run is under a hundred cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule // lsw_status_word_tb_top
